// [dual_timer_defs.svh]
`ifndef DUAL_TIMER_DEFS_SVH
`define DUAL_TIMER_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_NARROW_CTL   14'hd00
`define IDX_WIDE_CTL     14'hd02
`define IDX_SHARED_CTL   14'hd03
`define IDX_WIDE_RELOAD  14'hd10
`define IDX_NARROW_RELOAD 14'hd11
`define IDX_CAPTURE      14'hd12
`define IDX_NARROW_CAP   14'hd13
`define IDX_IRQ_STATUS   14'hd20
`define IDX_IRQ_CLEAR    14'hd21
`define IDX_IRQ_ENABLE   14'hd22

// field positions
`define WC_EN_BIT        7
`define WC_MODE_BIT      6
`define WC_TIMEOUT_BIT   5
`define NC_EN_BIT        7

// interrupt status bits
`define IRQ_WIDE_TIMEOUT 0
`define IRQ_CAPTURE      1
`define IRQ_NARROW_DEMOD 2
`define IRQ_NARROW_TOUT  3
`define IRQ_BITS         4

// reset values
`define SHARED_RST       8'h00
`define WIDE_CTL_RST     8'h00
`define NARROW_CTL_RST   8'h00
`define WIDE_RELOAD_RST  16'hffff
`define NARROW_RELOAD_RST 8'hff

// one-cycle capture edge numbers
`define EDGE_ACTIVE      3'h3
`define EDGE_CAP_FIRST   3'h4
`define EDGE_CAP_LAST    3'h5

`endif

// [dual_timer_pkg.sv]
package dual_timer_pkg;

  typedef struct packed {
    logic       wide_count_enable;
    logic       narrow_count_enable;
    logic       sync_mode;
    logic       wide_output_freeze;
    logic       narrow_one_cycle_capture;
    logic [2:0] reserved;
  } shared_ctl_t;

  typedef struct packed {
    logic       wide_count_enable;
    logic       single_pass;
    logic       timeout_flag;
    logic [1:0] wide_clock_select;
    logic       capture_int_enable;
    logic       counter_int_enable;
    logic       pin5_timer_route;
  } wide_ctl_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [15:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avs_rsp_t;

  typedef enum logic [1:0] {
    CLK_DIV1,
    CLK_DIV2,
    CLK_DIV4,
    CLK_DIV8
  } clk_sel_t;

endpackage

// [dual_timer_control.sv]
// Functional notes
// - clock select 00/01/10/11 divides the system clock by 1/2/4/8
// - clock select field survives stop-mode recovery
// - capture interrupt on low or high capture only when enabled; retained
// - wide time-out interrupt only when counter interrupt enable is 1
// - route bit 0 drives pin from port latch, 1 from wide timer output
// - writing both shared enables at once starts both counters together
// - narrow counter runs when either narrow enable bit is 1
// - shared control freezes the wide timer output level
// - shared control selects one-cycle carrier capture for narrow timer
// - output freeze stops toggling, time-outs still interrupt; retained
// - one-cycle: arm edge 3, capture 4 and 5, irq on 5, time-out restarts
`timescale 1ns/100ps
`include "dual_timer_defs.svh"

module dual_timer_control #(
  parameter int WIDE_W   = 16,
  parameter int NARROW_W = 8
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  // register bus
  input  dual_timer_pkg::avs_req_t   avs_req,
  output dual_timer_pkg::avs_rsp_t   avs_rsp,
  // timer environment
  input  wire logic                  stop_recovery,
  input  wire logic                  demod_in,
  input  wire logic                  demod_mode,
  input  wire logic                  port_latch,
  // pin and interrupt
  output logic                       port3_pin5,
  output logic                       irq
);
  import dual_timer_pkg::*;

  generate
    if (WIDE_W < 2 || WIDE_W > 16 ||
        NARROW_W < 2 || NARROW_W > 8) begin : g_chk
      $error("timer widths must be 2..16 and 2..8");
    end
  endgenerate

  shared_ctl_t           shared_q;
  wide_ctl_t             wide_ctl_q;
  logic                  narrow_en_q;
  logic [WIDE_W-1:0]     wide_reload_q, wide_cnt_q;
  logic [NARROW_W-1:0]   narrow_reload_q, narrow_cnt_q, narrow_cap_q;
  logic [WIDE_W-1:0]     cap_low_q, cap_high_q;
  logic [`IRQ_BITS-1:0]  irq_status_q, irq_enable_q, irq_event;
  logic                  ack_q;
  logic [31:0]           rdata_q;
  logic [2:0]            presc_q, edge_cnt_q;
  logic                  wide_out_q, wide_run_prev_q, narrow_run_prev_q;
  logic                  demod_prev_q, wide_stopped_q, pin_q;

  // bus decode; one wait state on every access
  logic        req, wr_go, rd_go;
  logic [13:0] idx;
  assign req   = avs_req.read | avs_req.write;
  assign idx   = avs_req.address[15:2];
  assign wr_go = avs_req.write & ack_q;
  assign rd_go = avs_req.read & ~ack_q;
  assign avs_rsp.waitrequest = req & ~ack_q;
  assign avs_rsp.readdata    = rdata_q;

  logic wr_shared, wr_wide, wr_narrow, wr_wrl, wr_nrl, wr_clr, wr_ien;
  assign wr_shared = wr_go & avs_req.byteenable[0] &
                     (idx == `IDX_SHARED_CTL);
  assign wr_wide   = wr_go & avs_req.byteenable[0] & (idx == `IDX_WIDE_CTL);
  assign wr_narrow = wr_go & avs_req.byteenable[0] &
                     (idx == `IDX_NARROW_CTL);
  assign wr_wrl    = wr_go & (&avs_req.byteenable[1:0]) &
                     (idx == `IDX_WIDE_RELOAD);
  assign wr_nrl    = wr_go & avs_req.byteenable[0] &
                     (idx == `IDX_NARROW_RELOAD);
  assign wr_clr    = wr_go & avs_req.byteenable[0] & (idx == `IDX_IRQ_CLEAR);
  assign wr_ien    = wr_go & avs_req.byteenable[0] &
                     (idx == `IDX_IRQ_ENABLE);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // effective enables: either copy of an enable bit runs the counter
  logic wide_run, narrow_run;
  assign wide_run   = wide_ctl_q.wide_count_enable |
                      shared_q.wide_count_enable;
  assign narrow_run = narrow_en_q | shared_q.narrow_count_enable;

  // shared control; recovery drops enables only, other bits are kept
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shared_q <= shared_ctl_t'(`SHARED_RST);
    end else if (wr_shared) begin
      shared_q          <= shared_ctl_t'(avs_req.writedata[7:0]);
      shared_q.reserved <= 3'h0;
    end else if (stop_recovery) begin
      shared_q.wide_count_enable   <= 1'b0;
      shared_q.narrow_count_enable <= 1'b0;
    end
  end

  // wide control; time-out flag set wins over its write-one clear
  logic wide_tc;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wide_ctl_q <= wide_ctl_t'(`WIDE_CTL_RST);
    end else begin
      if (wr_wide) begin
        wide_ctl_q.wide_count_enable  <= avs_req.writedata[`WC_EN_BIT];
        wide_ctl_q.single_pass        <= avs_req.writedata[`WC_MODE_BIT];
        wide_ctl_q.wide_clock_select  <= avs_req.writedata[4:3];
        wide_ctl_q.capture_int_enable <= avs_req.writedata[2];
        wide_ctl_q.counter_int_enable <= avs_req.writedata[1];
        wide_ctl_q.pin5_timer_route   <= avs_req.writedata[0];
      end else if (stop_recovery) begin
        // select, masks and route stay as written
        wide_ctl_q.wide_count_enable <= 1'b0;
      end
      if (wide_tc) begin
        wide_ctl_q.timeout_flag <= 1'b1;
      end else if (wr_wide && avs_req.writedata[`WC_TIMEOUT_BIT]) begin
        wide_ctl_q.timeout_flag <= 1'b0;
      end
    end
  end

  // narrow control enable and reload values
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      narrow_en_q     <= 1'(`NARROW_CTL_RST >> `NC_EN_BIT);
      wide_reload_q   <= WIDE_W'(`WIDE_RELOAD_RST);
      narrow_reload_q <= NARROW_W'(`NARROW_RELOAD_RST);
    end else begin
      if (wr_narrow) begin
        narrow_en_q <= avs_req.writedata[`NC_EN_BIT];
      end else if (stop_recovery) begin
        narrow_en_q <= 1'b0;
      end
      if (wr_wrl) begin
        wide_reload_q <= avs_req.writedata[WIDE_W-1:0];
      end
      if (wr_nrl) begin
        narrow_reload_q <= avs_req.writedata[NARROW_W-1:0];
      end
    end
  end

  // prescaler restarts whenever the counter starts, so with clock select 00 both timers
  // enabled by one write take their first step on the same edge
  logic wide_start, narrow_start, wide_tick;
  logic [2:0] presc_mask;
  assign wide_start   = wide_run & ~wide_run_prev_q;
  assign narrow_start = narrow_run & ~narrow_run_prev_q;
  always_comb begin
    case (clk_sel_t'(wide_ctl_q.wide_clock_select))
      CLK_DIV1: presc_mask = 3'h0;
      CLK_DIV2: presc_mask = 3'h1;
      CLK_DIV4: presc_mask = 3'h3;
      CLK_DIV8: presc_mask = 3'h7;
      default:  presc_mask = 3'h0;
    endcase
  end
  assign wide_tick = wide_run & ~wide_start & ~wide_stopped_q &
                     ((presc_q & presc_mask) == presc_mask);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_q           <= 3'h0;
      wide_run_prev_q   <= 1'b0;
      narrow_run_prev_q <= 1'b0;
    end else begin
      wide_run_prev_q   <= wide_run;
      narrow_run_prev_q <= narrow_run;
      if (!wide_run || wide_start) begin
        presc_q <= 3'h0;
      end else begin
        presc_q <= presc_q + 3'h1;
      end
    end
  end

  // wide counter: counts down, reloads or stops at terminal count
  assign wide_tc = wide_tick && (wide_cnt_q == '0);
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wide_cnt_q     <= '0;
      wide_stopped_q <= 1'b0;
    end else if (wide_start) begin
      wide_cnt_q     <= wide_reload_q;
      wide_stopped_q <= 1'b0;
    end else if (wide_tc) begin
      wide_cnt_q     <= wide_reload_q;
      wide_stopped_q <= wide_ctl_q.single_pass & ~demod_mode;
    end else if (wide_tick) begin
      wide_cnt_q <= wide_cnt_q - WIDE_W'(1);
    end
  end

  // output toggles on time-out unless frozen; time-outs still count
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wide_out_q <= 1'b0;
    end else if (wide_tc && !shared_q.wide_output_freeze) begin
      wide_out_q <= ~wide_out_q;
    end
  end

  // pin from a flop so it never glitches on a route change
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= wide_ctl_q.pin5_timer_route ? wide_out_q : port_latch;
    end
  end
  assign port3_pin5 = pin_q;

  // carrier edges; the input is taken as synchronous to mclk
  logic demod_rise, demod_fall, demod_edge;
  assign demod_rise = demod_in & ~demod_prev_q;
  assign demod_fall = ~demod_in & demod_prev_q;
  assign demod_edge = demod_rise | demod_fall;

  // wide capture: rising edge ends a low phase, falling a high phase
  logic wide_capture;
  assign wide_capture = demod_mode & wide_run & demod_edge;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      demod_prev_q <= 1'b0;
      cap_low_q    <= '0;
      cap_high_q   <= '0;
    end else begin
      demod_prev_q <= demod_in;
      if (wide_capture && demod_rise) begin
        cap_low_q <= wide_cnt_q;
      end
      if (wide_capture && demod_fall) begin
        cap_high_q <= wide_cnt_q;
      end
    end
  end

  // narrow counter, one step per mclk while running
  logic narrow_tc;
  assign narrow_tc = narrow_run & ~narrow_start & (narrow_cnt_q == '0);
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      narrow_cnt_q <= '0;
    end else if (narrow_start || narrow_tc) begin
      narrow_cnt_q <= narrow_reload_q;
    end else if (narrow_run) begin
      narrow_cnt_q <= narrow_cnt_q - NARROW_W'(1);
    end
  end

  // one-cycle capture: edge count saturates at five until a time-out
  logic narrow_cap_ev, narrow_irq_ev;
  logic [2:0] edge_next;
  assign edge_next = edge_cnt_q + 3'h1;
  always_comb begin
    if (!shared_q.narrow_one_cycle_capture) begin
      narrow_cap_ev = narrow_run & demod_edge;
      narrow_irq_ev = narrow_cap_ev;
    end else begin
      narrow_cap_ev = narrow_run & demod_edge & ~narrow_tc &
                      (edge_next == `EDGE_CAP_FIRST ||
                       edge_next == `EDGE_CAP_LAST);
      narrow_irq_ev = narrow_cap_ev & (edge_next == `EDGE_CAP_LAST);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      edge_cnt_q   <= 3'h0;
      narrow_cap_q <= '0;
    end else begin
      if (narrow_tc || !narrow_run || !shared_q.narrow_one_cycle_capture) begin
        edge_cnt_q <= 3'h0;
      end else if (demod_edge && edge_cnt_q != `EDGE_CAP_LAST) begin
        edge_cnt_q <= edge_next;
      end
      if (narrow_cap_ev) begin
        narrow_cap_q <= narrow_cnt_q;
      end
    end
  end

  // interrupts: wide events are masked at their source, then all are held sticky
  always_comb begin
    irq_event = '0;
    irq_event[`IRQ_WIDE_TIMEOUT] = wide_tc &
                                   wide_ctl_q.counter_int_enable;
    irq_event[`IRQ_CAPTURE]      = wide_capture &
                                   wide_ctl_q.capture_int_enable;
    irq_event[`IRQ_NARROW_DEMOD] = narrow_irq_ev;
    irq_event[`IRQ_NARROW_TOUT]  = narrow_tc;
  end

  // a new event in the clearing cycle stays set
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status_q <= '0;
      irq_enable_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q &
                       ~(wr_clr ? avs_req.writedata[`IRQ_BITS-1:0] : '0)) |
                      irq_event;
      if (wr_ien) begin
        irq_enable_q <= avs_req.writedata[`IRQ_BITS-1:0];
      end
    end
  end
  assign irq = |(irq_status_q & irq_enable_q);

  // read data is captured in the cycle before the answer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 32'h0;
    end else if (rd_go) begin
      case (idx)
        `IDX_SHARED_CTL:    rdata_q <= {24'h0, shared_q};
        `IDX_WIDE_CTL:      rdata_q <= {24'h0, wide_ctl_q};
        `IDX_NARROW_CTL:    rdata_q <= {24'h0, narrow_en_q, 7'h0};
        `IDX_WIDE_RELOAD:   rdata_q <= 32'(wide_reload_q);
        `IDX_NARROW_RELOAD: rdata_q <= 32'(narrow_reload_q);
        `IDX_CAPTURE:       rdata_q <= {16'(cap_high_q), 16'(cap_low_q)};
        `IDX_NARROW_CAP:    rdata_q <= 32'(narrow_cap_q);
        `IDX_IRQ_STATUS:    rdata_q <= 32'(irq_status_q);
        `IDX_IRQ_ENABLE:    rdata_q <= 32'(irq_enable_q);
        default:            rdata_q <= 32'h0;
      endcase
    end
  end

endmodule

// [dual_timer_monitor.sv]
`timescale 1ns/100ps
`include "dual_timer_defs.svh"
module dual_timer_monitor (
  // clock and reset
  input wire logic                mclk,
  input wire logic                sys_rst,
  // register bus
  input dual_timer_pkg::avs_req_t avs_req,
  input dual_timer_pkg::avs_rsp_t avs_rsp,
  // pin and interrupt
  input wire logic                port_latch,
  input wire logic                port3_pin5,
  input wire logic                irq
);
  import dual_timer_pkg::*;
  logic [13:0] idx;
  logic        wr_ok;
  logic        rd_ok;
  logic        route_q;
  logic        frz_q;
  logic [3:0]  ien_q;
  assign idx   = avs_req.address[15:2];
  assign rd_ok = avs_req.read & ~avs_rsp.waitrequest;
  assign wr_ok = avs_req.write & ~avs_rsp.waitrequest
                 & avs_req.byteenable[0];
  // shadows only of bits that stop recovery leaves alone
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      route_q <= 1'b0;
      frz_q   <= 1'b0;
      ien_q   <= 4'h0;
    end else if (wr_ok) begin
      if (idx == `IDX_WIDE_CTL) route_q <= avs_req.writedata[0];
      if (idx == `IDX_SHARED_CTL) frz_q <= avs_req.writedata[4];
      if (idx == `IDX_IRQ_ENABLE) ien_q <= avs_req.writedata[3:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wait_state_a: assert property (
    (avs_req.read | avs_req.write) && avs_rsp.waitrequest
    |=> !avs_rsp.waitrequest) else $error("bus answer late");
  one_wait_a: assert property (
    (rd_ok || (avs_req.write && !avs_rsp.waitrequest))
    |=> (avs_rsp.waitrequest || !(avs_req.read | avs_req.write)))
    else $error("waitrequest low too long");
  rst_quiet_a: assert property ($fell(sys_rst) |-> !irq && !port3_pin5)
    else $error("outputs active out of reset");
  hole_zero_a: assert property (
    rd_ok && idx == 14'h3ff |-> avs_rsp.readdata == 32'h0)
    else $error("unmapped read not zero");
  resv_zero_a: assert property (
    rd_ok && idx == `IDX_SHARED_CTL |-> avs_rsp.readdata[2:0] == 3'h0)
    else $error("reserved shared bits not zero");
  pin_latch_a: assert property (
    !route_q |=> port3_pin5 == $past(port_latch))
    else $error("pin not following port latch");
  pin_freeze_a: assert property (
    (route_q && frz_q) [*4] |-> $stable(port3_pin5))
    else $error("frozen pin toggled");
  irq_enable_a: assert property (
    irq |-> ien_q != 4'h0) else $error("irq without enable");
  cover property (irq ##1 !irq);
  cover property ((route_q && frz_q) [*4]);
  cover property (rd_ok && idx == 14'h3ff);
endmodule
bind dual_timer_control dual_timer_monitor dual_timer_monitor_inst (
  .mclk(mclk), .sys_rst(sys_rst), .avs_req(avs_req), .avs_rsp(avs_rsp),
  .port_latch(port_latch), .port3_pin5(port3_pin5), .irq(irq));

// [test_dual_timer_control.sv]
`timescale 1ns/100ps
`include "dual_timer_defs.svh"
module test_dual_timer_control;
  import dual_timer_pkg::*;
  logic     mclk = 1'b0;
  logic     sys_rst = 1'b1;
  avs_req_t avs_req = '0;
  avs_rsp_t avs_rsp;
  logic     stop_recovery = 1'b0;
  logic     demod_in = 1'b0;
  logic     demod_mode = 1'b0;
  logic     port_latch = 1'b0;
  logic     port3_pin5;
  logic     irq;
  int       mismatches = 0;
  int       n_checks = 0;
  int       p0 = 4; // reload 3: four ticks between toggles
  int       p = 0;

  dual_timer_control dual_timer_control_inst (
    .mclk(mclk), .sys_rst(sys_rst), .avs_req(avs_req), .avs_rsp(avs_rsp),
    .stop_recovery(stop_recovery), .demod_in(demod_in),
    .demod_mode(demod_mode), .port_latch(port_latch),
    .port3_pin5(port3_pin5), .irq(irq));

  always #12.5 mclk = ~mclk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic give_up(input string what);
    mismatches++;
    $display("mismatch %s expected done seen timeout", what);
    print_verdict();
  endtask

  task automatic cmp(input string what, input logic [31:0] e,
                     input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [13:0] ix,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    rd = 32'h0;
    @(posedge mclk);
    avs_req <= '{read: ~wr, write: wr, address: {ix, 2'b00},
                 writedata: wd, byteenable: 4'hf};
    do begin
      @(posedge mclk);
      n++;
    end while (avs_rsp.waitrequest !== 1'b0 && n < 50);
    if (n >= 50) give_up("bus answer");
    rd = avs_rsp.readdata;
    avs_req <= '0;
  endtask

  task automatic wreg(input logic [13:0] ix, input logic [15:0] d);
    logic [31:0] x;
    bus(1'b1, ix, {16'h0, d}, x);
  endtask

  task automatic rchk(input string what, input logic [13:0] ix,
                      input logic [31:0] m, input logic [31:0] e);
    logic [31:0] rd;
    bus(1'b0, ix, 32'h0, rd);
    cmp(what, e, rd & m);
  endtask

  // cycles between two pin toggles
  task automatic period(output int q);
    logic lv;
    int   n;
    n = 0;
    q = 0;
    @(negedge mclk);
    lv = port3_pin5;
    while (port3_pin5 === lv && n < 400) begin
      @(negedge mclk);
      n++;
    end
    lv = port3_pin5;
    while (port3_pin5 === lv && n < 800) begin
      @(negedge mclk);
      n++;
      q++;
    end
    if (n >= 800) give_up("pin toggle");
  endtask

  task automatic still(input string what);
    logic lv;
    int   ch;
    ch = 0;
    @(negedge mclk);
    lv = port3_pin5;
    repeat (80) begin
      @(negedge mclk);
      if (port3_pin5 !== lv) ch++;
    end
    cmp(what, 32'h0, ch);
  endtask

  task automatic edge_in();
    @(posedge mclk);
    demod_in <= ~demod_in;
    repeat (3) @(posedge mclk);
  endtask

  task automatic t_reset();
    rchk("shared ctl", `IDX_SHARED_CTL, 32'hf8, 32'h0);
    rchk("wide ctl", `IDX_WIDE_CTL, 32'hff, 32'h0);
    rchk("unmapped", 14'h3ff, 32'hffffffff, 32'h0);
    @(negedge mclk);
    cmp("irq idle", 32'h0, {31'h0, irq});
    $display("done reset");
  endtask

  task automatic t_clock();
    wreg(`IDX_WIDE_RELOAD, 16'h3);
    for (int s = 0; s < 4; s++) begin
      wreg(`IDX_WIDE_CTL, {9'h1, 2'h0, s[1:0], 3'h1});
      period(p);
      cmp("wide period", p0 << s, p);
    end
    $display("done clock select");
  endtask

  task automatic t_freeze();
    wreg(`IDX_WIDE_CTL, 16'h9b);
    wreg(`IDX_IRQ_CLEAR, 16'hf);
    wreg(`IDX_SHARED_CTL, 16'h10);
    still("frozen pin");
    rchk("timeout when frozen", `IDX_IRQ_STATUS, 32'h1, 32'h1);
    wreg(`IDX_SHARED_CTL, 16'h0);
    period(p);
    cmp("unfrozen period", p0 * 8, p);
    $display("done freeze");
  endtask

  task automatic t_irq();
    wreg(`IDX_WIDE_CTL, 16'h98);
    wreg(`IDX_IRQ_CLEAR, 16'hf);
    repeat (100) @(posedge mclk);
    rchk("masked timeout", `IDX_IRQ_STATUS, 32'h1, 32'h0);
    wreg(`IDX_IRQ_ENABLE, 16'h1);
    wreg(`IDX_WIDE_CTL, 16'h9a);
    repeat (100) @(negedge mclk);
    cmp("irq raised", 32'h1, {31'h0, irq});
    wreg(`IDX_IRQ_ENABLE, 16'h0);
    @(negedge mclk);
    cmp("irq masked", 32'h0, {31'h0, irq});
    wreg(`IDX_WIDE_CTL, 16'h0);
    wreg(`IDX_IRQ_CLEAR, 16'hf);
    rchk("status cleared", `IDX_IRQ_STATUS, 32'hf, 32'h0);
    $display("done interrupt");
  endtask

  task automatic t_route();
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      port_latch <= ~port_latch;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      cmp("pin from latch", {31'h0, port_latch}, {31'h0, port3_pin5});
    end
    $display("done route");
  endtask

  task automatic t_stop();
    wreg(`IDX_WIDE_CTL, 16'h9e);
    wreg(`IDX_SHARED_CTL, 16'hf8);
    wreg(`IDX_NARROW_CTL, 16'h80);
    @(posedge mclk);
    stop_recovery <= 1'b1;
    @(posedge mclk);
    stop_recovery <= 1'b0;
    rchk("wide kept", `IDX_WIDE_CTL, 32'h9f, 32'h1e);
    rchk("shared kept", `IDX_SHARED_CTL, 32'hf8, 32'h38);
    rchk("narrow off", `IDX_NARROW_CTL, 32'h80, 32'h0);
    wreg(`IDX_SHARED_CTL, 16'h0);
    $display("done stop recovery");
  endtask

  task automatic t_enables();
    wreg(`IDX_WIDE_CTL, 16'h19);
    wreg(`IDX_SHARED_CTL, 16'h80);
    period(p);
    cmp("shared enable", p0 * 8, p);
    wreg(`IDX_SHARED_CTL, 16'h0);
    still("both enables off");
    wreg(`IDX_NARROW_RELOAD, 16'h2);
    for (int i = 0; i < 3; i++) begin
      wreg(`IDX_IRQ_CLEAR, 16'hf);
      wreg(i == 0 ? `IDX_SHARED_CTL : `IDX_NARROW_CTL, i == 1 ? 16'h0 :
           (i == 0 ? 16'h40 : 16'h80));
      repeat (20) @(posedge mclk);
      rchk("narrow run", `IDX_IRQ_STATUS, 32'h8, i == 1 ? 32'h0 : 32'h8);
      if (i == 0) wreg(`IDX_SHARED_CTL, 16'h0);
    end
    wreg(`IDX_NARROW_CTL, 16'h0);
    wreg(`IDX_NARROW_RELOAD, 16'hff);
    wreg(`IDX_WIDE_CTL, 16'h0);
    $display("done enables");
  endtask

  task automatic t_capture();
    // second pass after a narrow time-out must capture edges 4 and 5 again
    for (int k = 0; k < 2; k++) begin
      wreg(`IDX_IRQ_CLEAR, 16'hf);
      if (k == 0) wreg(`IDX_SHARED_CTL, 16'h48);
      else repeat (300) @(posedge mclk);
      repeat (4) edge_in();
      rchk("fourth edge", `IDX_IRQ_STATUS, 32'h4, 32'h0);
      edge_in();
      rchk("fifth edge", `IDX_IRQ_STATUS, 32'h4, 32'h4);
    end
    wreg(`IDX_SHARED_CTL, 16'h0);
    demod_mode <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wreg(`IDX_WIDE_CTL, i == 0 ? 16'h84 : 16'h80);
      wreg(`IDX_IRQ_CLEAR, 16'hf);
      edge_in();
      rchk("capture", `IDX_IRQ_STATUS, 32'h2, i == 0 ? 32'h2 : 32'h0);
    end
    // both enables in one write: both counts equal the reload at one edge
    wreg(`IDX_WIDE_CTL, 16'h0);
    wreg(`IDX_NARROW_RELOAD, 16'h3);
    wreg(`IDX_SHARED_CTL, 16'hc0);
    edge_in();
    rchk("sync wide", `IDX_CAPTURE, 32'hffff, 32'h3);
    rchk("sync narrow", `IDX_NARROW_CAP, 32'hff, 32'h3);
    wreg(`IDX_SHARED_CTL, 16'h0);
    demod_mode <= 1'b0;
    $display("done capture");
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    give_up("whole run");
  end

  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_clock();
    t_freeze();
    t_irq();
    t_route();
    t_stop();
    t_enables();
    t_capture();
    print_verdict();
  end
endmodule
